// ### design/dsmc_consts.svh
// Constants of the snoop and mode control block
`ifndef DSMC_CONSTS_SVH
`define DSMC_CONSTS_SVH
`define DSMC_CLK_MHZ 25
`define DSMC_HPD_TIME_US 2000
`define DSMC_HPD_CYCLES (`DSMC_HPD_TIME_US * `DSMC_CLK_MHZ)
`define DSMC_DDC_ADDR 8'hA8
`define DSMC_OFF_TMDS 8'h20
`define DSMC_OFF_SINK 8'h31
`define DSMC_OFF_TEST 8'h35
`define DSMC_OFF_STAT0 8'h40
`define DSMC_OFF_STAT1 8'h41
`define DSMC_OFF_STAT2 8'h42
`define DSMC_RATIO_BIT 1
`define DSMC_FRL_LSB 0
`define DSMC_FRL_MSB 3
`define DSMC_RATE_3L3G 4'h1
`define DSMC_RATE_3L6G 4'h2
`define DSMC_RATE_4L6G 4'h3
`define DSMC_RATE_MAX 4'h6
`define DSMC_LIN_21 2'h3
`define DSMC_ADDR_WR 32'h0000_0000
`define DSMC_ADDR_STAT 32'h0000_0004
`define DSMC_ADDR_SNP0 32'h0000_0008
`define DSMC_ADDR_SNP1 32'h0000_000C
`endif

// ### design/dsmc_pkg.sv
// Types of the snoop and mode control block
package dsmc_pkg;
   typedef enum logic [1:0] {
      DSMC_LVL_L = 2'h0,
      DSMC_LVL_R = 2'h1,
      DSMC_LVL_F = 2'h2,
      DSMC_LVL_H = 2'h3
   } dsmc_level_type;
   typedef enum logic [2:0] {
      DSMC_HDMI14 = 3'h1,
      DSMC_HDMI20 = 3'h2,
      DSMC_HDMI21 = 3'h4
   } dsmc_link_type;
   typedef enum logic [4:0] {
      DSMC_S_IDLE = 5'h01,
      DSMC_S_ADDR = 5'h02,
      DSMC_S_OFFS = 5'h04,
      DSMC_S_DATA = 5'h08,
      DSMC_S_SKIP = 5'h10
   } dsmc_snoop_state_type;
   // Termination codes: 0 AC 50 to supply, 1 150, 2 75, 3 50 to supply, 4 100 l2l, 5 300 l2l
   typedef struct packed {
      logic dc_coupled;
      logic snoop_enable;
      logic output_fault_detect_enable;
      logic low_power;
      logic frl_mode;
      logic lane_d_is_clock;
      logic [2:0] link_mode;
      logic [3:0] frl_rate;
      logic [1:0] eq_level;
      logic [1:0] flat_gain;
      logic [1:0] swing_level;
      logic [2:0] output_termination;
      logic [2:0] lane3_termination;
   } dsmc_ctrl_type;
endpackage

// ### design/dsmc_top.sv
// Strap decode, DDC snooper and link settings with an AXI4-Lite status port
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dsmc_consts.svh"
module dsmc_top #(
   parameter int HPD_CYCLES = `DSMC_HPD_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] mode_strap,
   input wire logic [1:0] low_rate_eq_select,
   input wire logic [1:0] high_rate_eq_select,
   input wire logic [1:0] flat_gain_select,
   input wire logic [1:0] legacy_output_level_select,
   input wire logic [1:0] linearity_level_select,
   input wire logic hpd,
   input wire logic ddc_scl,
   input wire logic ddc_sda,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output dsmc_pkg::dsmc_ctrl_type ctrl
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Strap and DDC pins are asynchronous, so all pass two flip-flops
   logic [14:0] sync1_reg;
   logic [14:0] sync2_reg;
   logic [14:0] pins_in;
   assign pins_in = {ddc_sda, ddc_scl, hpd, linearity_level_select, legacy_output_level_select,
                     flat_gain_select, high_rate_eq_select, low_rate_eq_select, mode_strap};
   always_ff @(posedge aclk) begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
   end
   wire [1:0] mode_s = sync2_reg[1:0];
   wire [1:0] eql_s = sync2_reg[3:2];
   wire [1:0] eqh_s = sync2_reg[5:4];
   wire [1:0] fg_s = sync2_reg[7:6];
   wire [1:0] sw_s = sync2_reg[9:8];
   wire [1:0] lin_s = sync2_reg[11:10];
   wire hpd_s = sync2_reg[12];
   wire scl_s = sync2_reg[13];
   wire sda_s = sync2_reg[14];

   // ----------------------------------------
   // Hot-plug debounce
   // ----------------------------------------
   // A bounce shorter than HPD_CYCLES restarts the count, so the power state never chatters
   logic [31:0] hpd_cnt_reg;
   logic low_power_reg;
   wire hpd_differs = (hpd_s == low_power_reg);
   wire hpd_expired = hpd_differs && (hpd_cnt_reg >= 32'(HPD_CYCLES - 1));
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hpd_cnt_reg <= 32'h0000_0000;
         low_power_reg <= 1'b1;
      end else if (!hpd_differs || hpd_expired) begin
         hpd_cnt_reg <= 32'h0000_0000;
         if (hpd_expired) low_power_reg <= ~low_power_reg;
      end else begin
         hpd_cnt_reg <= hpd_cnt_reg + 32'h0000_0001;
      end
   end

   // ----------------------------------------
   // DDC snooper, sampled only, never driven
   // ----------------------------------------
   logic scl_d_reg;
   logic sda_d_reg;
   always_ff @(posedge aclk) begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
   end
   wire scl_rise = scl_s && !scl_d_reg;
   wire start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s;
   wire stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;
   wire snoop_on = (mode_s != 2'h0) && !low_power_reg;

   dsmc_pkg::dsmc_snoop_state_type state_reg;
   dsmc_pkg::dsmc_snoop_state_type state_next;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] offset_reg;
   logic is_read_reg;
   logic [7:0] tmds_cfg_reg;
   logic [7:0] frl_cfg_reg;
   logic [7:0] test_cfg_reg;
   logic [23:0] status_reg;
   // The ninth clock is the acknowledge slot; it is skipped, not answered
   wire byte_done = scl_rise && (bit_cnt_reg == 4'h8);
   wire [7:0] rx_byte = shift_reg;
   // Bit 0 is the direction, so both the write and the read form of the address hit
   wire addr_hit = ({rx_byte[7:1], 1'b0} == `DSMC_DDC_ADDR);
   wire data_byte = (state_reg == dsmc_pkg::DSMC_S_DATA) && byte_done;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         dsmc_pkg::DSMC_S_IDLE: state_next = state_reg;
         dsmc_pkg::DSMC_S_ADDR: if (byte_done) begin
            if (!addr_hit) state_next = dsmc_pkg::DSMC_S_SKIP;
            else if (rx_byte[0]) state_next = dsmc_pkg::DSMC_S_DATA;
            else state_next = dsmc_pkg::DSMC_S_OFFS;
         end
         dsmc_pkg::DSMC_S_OFFS: if (byte_done) state_next = dsmc_pkg::DSMC_S_DATA;
         dsmc_pkg::DSMC_S_DATA: state_next = state_reg;
         dsmc_pkg::DSMC_S_SKIP: state_next = state_reg;
      endcase
      if (start_cond) state_next = dsmc_pkg::DSMC_S_ADDR;
      if (stop_cond || !snoop_on) state_next = dsmc_pkg::DSMC_S_IDLE;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= dsmc_pkg::DSMC_S_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         is_read_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (start_cond || byte_done) bit_cnt_reg <= 4'h0;
         else if (scl_rise) bit_cnt_reg <= bit_cnt_reg + 4'h1;
         if (scl_rise && bit_cnt_reg < 4'h8) shift_reg <= {shift_reg[6:0], sda_s};
         if (state_reg == dsmc_pkg::DSMC_S_ADDR && byte_done) is_read_reg <= rx_byte[0];
      end
   end

   // Offset survives the stop so a later read-only transfer continues from it
   always_ff @(posedge aclk) begin
      if (!aresetn || low_power_reg) begin
         offset_reg <= 8'h00;
         tmds_cfg_reg <= 8'h00;
         frl_cfg_reg <= 8'h00;
         test_cfg_reg <= 8'h00;
         status_reg <= 24'h00_0000;
      end else if (state_reg == dsmc_pkg::DSMC_S_OFFS && byte_done) begin
         offset_reg <= rx_byte;
      end else if (data_byte) begin
         offset_reg <= offset_reg + 8'h01;
         unique case (offset_reg)
            `DSMC_OFF_TMDS: tmds_cfg_reg <= rx_byte;
            `DSMC_OFF_SINK: frl_cfg_reg <= rx_byte;
            `DSMC_OFF_TEST: test_cfg_reg <= rx_byte;
            `DSMC_OFF_STAT0: status_reg[7:0] <= rx_byte;
            `DSMC_OFF_STAT1: status_reg[15:8] <= rx_byte;
            `DSMC_OFF_STAT2: status_reg[23:16] <= rx_byte;
            default: offset_reg <= offset_reg + 8'h01;
         endcase
      end
   end

   // ----------------------------------------
   // Link mode and analog settings
   // ----------------------------------------
   // Strap L has no snooped state, so it sits at the fixed 2.1, 12 Gbps, four-lane default
   wire mode_ac = (mode_s == 2'h0);
   wire [3:0] rate = mode_ac ? `DSMC_RATE_MAX : frl_cfg_reg[`DSMC_FRL_MSB:`DSMC_FRL_LSB];
   wire frl = (rate != 4'h0);
   wire three_lane = frl && (rate <= `DSMC_RATE_3L6G) && !mode_ac;
   wire tmds20 = tmds_cfg_reg[`DSMC_RATIO_BIT];
   wire [2:0] link = frl ? 3'(dsmc_pkg::DSMC_HDMI21) :
                     tmds20 ? 3'(dsmc_pkg::DSMC_HDMI20) : 3'(dsmc_pkg::DSMC_HDMI14);
   // Rate code 3 is 6 Gbps on four lanes and so still takes the low-rate equaliser
   wire high_rate = frl && (rate > `DSMC_RATE_4L6G);
   wire [2:0] term14 = (mode_s == 2'h1) ? 3'h1 : (mode_s == 2'h2) ? 3'h2 : 3'h3;
   wire [2:0] term = mode_ac ? 3'h0 : (link == 3'(dsmc_pkg::DSMC_HDMI14)) ? term14 : 3'h4;
   wire [1:0] swing = (link == 3'(dsmc_pkg::DSMC_HDMI14)) ? sw_s :
                      (link == 3'(dsmc_pkg::DSMC_HDMI20)) ? lin_s : `DSMC_LIN_21;
   dsmc_pkg::dsmc_ctrl_type ctrl_next;
   always_comb begin
      ctrl_next.dc_coupled = !mode_ac;
      ctrl_next.snoop_enable = snoop_on;
      ctrl_next.output_fault_detect_enable = !mode_ac && (link != 3'(dsmc_pkg::DSMC_HDMI14));
      ctrl_next.low_power = low_power_reg;
      ctrl_next.frl_mode = frl;
      ctrl_next.lane_d_is_clock = !frl;
      ctrl_next.link_mode = link;
      ctrl_next.frl_rate = rate;
      ctrl_next.eq_level = high_rate ? eqh_s : eql_s;
      ctrl_next.flat_gain = fg_s;
      ctrl_next.swing_level = swing;
      ctrl_next.output_termination = term;
      ctrl_next.lane3_termination = three_lane ? 3'h5 : term;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) ctrl <= '0;
      else ctrl <= ctrl_next;
   end

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   // Scratch bit for software, stored and read back only; it steers nothing
   logic [31:0] wr_ctrl_reg;
   logic aw_got_reg;
   logic w_got_reg;
   logic [31:0] aw_addr_reg;
   assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire aw_now = s_axi_awvalid && s_axi_awready;
   wire w_now = s_axi_wvalid && s_axi_wready;
   wire wr_go = (aw_got_reg || aw_now) && (w_got_reg || w_now);
   wire [31:0] wr_addr = aw_got_reg ? aw_addr_reg : s_axi_awaddr;
   wire [31:0] status_word = {16'h0000, ctrl.frl_rate, 1'b0, ctrl.link_mode,
                              state_reg, ctrl.low_power, ctrl.snoop_enable, ctrl.dc_coupled};
   wire rd_hit = (s_axi_araddr == `DSMC_ADDR_WR) || (s_axi_araddr == `DSMC_ADDR_STAT) ||
                 (s_axi_araddr == `DSMC_ADDR_SNP0) || (s_axi_araddr == `DSMC_ADDR_SNP1);
   wire [31:0] rd_word = (s_axi_araddr == `DSMC_ADDR_WR) ? wr_ctrl_reg :
                         (s_axi_araddr == `DSMC_ADDR_STAT) ? status_word :
                         (s_axi_araddr == `DSMC_ADDR_SNP0) ?
                            {8'h00, test_cfg_reg, frl_cfg_reg, tmds_cfg_reg} :
                         (s_axi_araddr == `DSMC_ADDR_SNP1) ? {8'h00, status_reg} : 32'h0000_0000;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         aw_addr_reg <= 32'h0000_0000;
         wr_ctrl_reg <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h0000_0000;
      end else begin
         if (aw_now) aw_addr_reg <= s_axi_awaddr;
         aw_got_reg <= wr_go ? 1'b0 : (aw_got_reg || aw_now);
         w_got_reg <= wr_go ? 1'b0 : (w_got_reg || w_now);
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_addr == `DSMC_ADDR_WR) ? 2'h0 : 2'h2;
            if (wr_addr == `DSMC_ADDR_WR && s_axi_wstrb[0]) wr_ctrl_reg <= {31'h0, s_axi_wdata[0]};
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_eq_select: assert property (ctrl.frl_rate > `DSMC_RATE_4L6G |->
      ctrl.frl_mode && ctrl.eq_level == $past(eqh_s)) else $error("high rate eq not used");
   chk_ac_no_snoop: assert property (mode_s == 2'h0 |=> !ctrl.snoop_enable && !ctrl.dc_coupled)
      else $error("AC strap left snoop on");
   chk_fault_14: assert property (ctrl.link_mode == 3'h1 |-> !ctrl.output_fault_detect_enable)
      else $error("fault detect in 1.4");
   chk_lane_d_role: assert property (ctrl.link_mode != 3'h0 |->
      ctrl.lane_d_is_clock == (ctrl.link_mode != 3'h4)) else $error("lane D role wrong");
   chk_flat_gain: assert property ($changed(fg_s) |=> ctrl.flat_gain == $past(fg_s))
      else $error("flat gain not followed");
   chk_lp_clears: assert property (low_power_reg |=> status_reg == 24'h0 && frl_cfg_reg == 8'h0)
      else $error("snooped state kept in low power");
   chk_skip_other: assert property (state_reg == dsmc_pkg::DSMC_S_SKIP && !start_cond |=> !data_byte)
      else $error("foreign address captured");
   chk_lin_21: assert property (ctrl.link_mode == 3'h4 |-> ctrl.swing_level == `DSMC_LIN_21)
      else $error("2.1 swing not fixed");
   // Settings follow their synchronised pins one cycle late, hence the $past terms
   chk_eq_low: assert property (ctrl.link_mode != 3'h0 &&
      ctrl.frl_rate <= `DSMC_RATE_4L6G |-> ctrl.eq_level == $past(eql_s))
      else $error("low rate eq not used");
   chk_swing_14: assert property (ctrl.link_mode == 3'h1 |->
      ctrl.swing_level == $past(sw_s)) else $error("1.4 swing not followed");
   chk_lane3_term: assert property (ctrl.lane3_termination == 3'h5 |->
      ctrl.frl_mode && ctrl.dc_coupled && ctrl.frl_rate <= `DSMC_RATE_3L6G)
      else $error("300 ohm lane 3 outside three-lane mode");
   chk_ac_term: assert property (ctrl.link_mode != 3'h0 && !ctrl.dc_coupled |->
      ctrl.output_termination == 3'h0 && ctrl.lane3_termination == 3'h0)
      else $error("AC strap termination wrong");
   chk_fault_on: assert property (ctrl.dc_coupled && ctrl.link_mode != 3'h1 |->
      ctrl.output_fault_detect_enable) else $error("fault detect off in 2.0 or 2.1");
   chk_hpd_debounce: assert property (!hpd_differs |=> $stable(low_power_reg))
      else $error("power state changed without debounce");
   cov_frl: cover property (ctrl.frl_mode && !mode_ac);
   cov_read_hit: cover property (state_reg == dsmc_pkg::DSMC_S_ADDR && byte_done &&
      addr_hit && rx_byte[0]);
   cov_skip: cover property (state_reg == dsmc_pkg::DSMC_S_SKIP);
   cov_three_lane: cover property (ctrl.lane3_termination == 3'h5);
   cov_unplug: cover property ($rose(low_power_reg));
endmodule
`default_nettype wire

// ### tb/dsmc_ddc_source.sv
// DDC source model that drives SCL and SDA for snoop traffic
`timescale 1ns/1ps
`default_nettype none
module dsmc_ddc_source (
   input wire logic clk,
   output logic scl,
   output logic sda
);
   // Both lines idle at the pull-up level; SCL stands high between frames
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   // ----------------------------------------
   // Frame: START, n bytes, STOP; rs places a repeated START before byte rs
   // ----------------------------------------
   // SCL half period is 4 clocks, 320 ns per bit
   task automatic xfer(input logic [7:0] b [5], input int n, input int rs);
      for (int i = 0; i < n; i++) begin
         if (i == 0 || i == rs) begin
            sda <= 1'b1;
            hold(2);
            scl <= 1'b1;
            hold(2);
            sda <= 1'b0;
            hold(2);
            scl <= 1'b0;
            hold(2);
         end
         // Byte 0 carries the target address and direction
         for (int j = 7; j >= 0; j--) begin
            sda <= b[i][j];
            hold(2);
            scl <= 1'b1;
            hold(4);
            scl <= 1'b0;
            hold(2);
         end
         // Acknowledge slot: released line reads high through the pull-up
         sda <= 1'b1;
         hold(2);
         scl <= 1'b1;
         hold(4);
         scl <= 1'b0;
         hold(2);
      end
      sda <= 1'b0;
      hold(2);
      scl <= 1'b1;
      hold(2);
      sda <= 1'b1;
      hold(4);
   endtask
endmodule
`default_nettype wire

// ### tb/dsmc_top_tb.sv
// Self-checking bench for the snoop and mode control block
`timescale 1ns/1ps
`default_nettype none
`include "dsmc_consts.svh"
module dsmc_top_tb;
   typedef struct {int k; logic [33:0] e; logic [33:0] m;} dsmc_note_type;
   logic aclk, aresetn, hpd, ddc_scl, ddc_sda, probe;
   logic [1:0] mode_strap, low_rate_eq_select, high_rate_eq_select, flat_gain_select;
   logic [1:0] legacy_output_level_select, linearity_level_select;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, seed;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   dsmc_pkg::dsmc_ctrl_type ctrl;
   dsmc_note_type q[$];
   int err_total = 0;
   int samples_checked = 0;
   string nm [3] = '{"rdata", "bresp", "ctrl"};
   dsmc_top #(.HPD_CYCLES(20)) dut (.aclk(aclk), .aresetn(aresetn), .mode_strap(mode_strap),
      .low_rate_eq_select(low_rate_eq_select), .high_rate_eq_select(high_rate_eq_select),
      .flat_gain_select(flat_gain_select), .legacy_output_level_select(legacy_output_level_select),
      .linearity_level_select(linearity_level_select), .hpd(hpd), .ddc_scl(ddc_scl),
      .ddc_sda(ddc_sda), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .ctrl(ctrl));
   dsmc_ddc_source dm (.clk(aclk), .scl(ddc_scl), .sda(ddc_sda));
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // ----------------------------------------
   // Verdict, timeout and result checking
   // ----------------------------------------
   task print_verdict;
      if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task tmo;
      err_total++;
      $display("CHECK FAILED handshake expected answer seen none");
      print_verdict;
   endtask
   task automatic cmp(input int k, input logic [33:0] v);
      dsmc_note_type x;
      samples_checked++;
      if (q.size() == 0) begin
         err_total++;
         $display("CHECK FAILED %s expected none seen %h", nm[k], v);
         return;
      end
      x = q.pop_front();
      if (x.k != k || (v & x.m) !== x.e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm[k], x.e, v & x.m);
      end
   endtask
   always @(posedge aclk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready) cmp(0, {s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid === 1'b1 && s_axi_bready) cmp(1, {32'h0, s_axi_bresp});
      if (probe) cmp(2, {9'h0, ctrl});
   end
   // ----------------------------------------
   // Stimulus helpers and expected settings
   // ----------------------------------------
   function automatic logic [9:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[9:0];
   endfunction
   task automatic hold(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      logic aw_done;
      logic w_done;
      q.push_back('{1, {32'h0, r}, 34'h3});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      for (n = 0; n < 200 && !(aw_done && w_done); n++) begin
         @(posedge aclk);
         if (!aw_done && s_axi_awready === 1'b1) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready === 1'b1) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      if (!(aw_done && w_done)) tmo;
      for (n = 0; n < 200; n++) begin
         @(posedge aclk);
         if (s_axi_bvalid === 1'b1) break;
      end
      if (n == 200) tmo;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [31:0] a, input logic [33:0] e, input logic [33:0] m);
      int n;
      q.push_back('{0, e, m});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 200; n++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) break;
      end
      if (n == 200) tmo;
      s_axi_arvalid <= 1'b0;
      for (n = 0; n < 200; n++) begin
         @(posedge aclk);
         if (s_axi_rvalid === 1'b1) break;
      end
      if (n == 200) tmo;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   // Settings expected for a strap, link mode and link rate with hot plug held high
   task automatic pc(input logic [1:0] st, input logic [2:0] lk, input logic [3:0] rt);
      dsmc_pkg::dsmc_ctrl_type c;
      hold(8);
      c = '0;
      c.dc_coupled = (st != 2'h0);
      c.snoop_enable = c.dc_coupled;
      c.output_fault_detect_enable = c.dc_coupled && lk != 3'h1;
      c.frl_mode = (lk == 3'h4);
      c.lane_d_is_clock = !c.frl_mode;
      c.link_mode = lk;
      c.frl_rate = rt;
      c.eq_level = (rt >= 4'h4) ? high_rate_eq_select : low_rate_eq_select;
      c.flat_gain = flat_gain_select;
      c.swing_level = (lk == 3'h1) ? legacy_output_level_select :
         (lk == 3'h2) ? linearity_level_select : `DSMC_LIN_21;
      c.output_termination = !c.dc_coupled ? 3'h0 : (lk == 3'h1) ? {1'b0, st} : 3'h4;
      c.lane3_termination = (c.dc_coupled && c.frl_mode && rt <= `DSMC_RATE_3L6G) ? 3'h5 :
         c.output_termination;
      q.push_back('{2, {9'h0, c}, 34'h3FFFFFFFF});
      probe <= 1'b1;
      @(posedge aclk);
      probe <= 1'b0;
      @(posedge aclk);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 32'h47;
      {aresetn, hpd, probe, mode_strap, s_axi_wstrb} <= {5'h0, 4'hF};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} <= '0;
      {low_rate_eq_select, high_rate_eq_select, flat_gain_select, legacy_output_level_select,
         linearity_level_select} <= 10'h0;
      fork
         begin
            hold(20000);
            tmo;
         end
      join_none
      hold(10);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`DSMC_ADDR_STAT, 34'hC, 34'hFF);
      wr(`DSMC_ADDR_WR, 32'h1, 2'h0);
      rd(`DSMC_ADDR_WR, 34'h1, 34'h1);
      wr(`DSMC_ADDR_STAT, 32'h1, 2'h2);
      rd(32'h0000_0020, {2'h2, 32'h0}, '1);
      hpd <= 1'b1;
      hold(40);
      for (int st = 0; st < 4; st++) begin
         mode_strap <= st[1:0];
         for (int j = 0; j < 2; j++) begin
            {low_rate_eq_select, high_rate_eq_select, flat_gain_select,
               legacy_output_level_select, linearity_level_select} <= rnd();
            pc(st[1:0], (st == 0) ? 3'h4 : 3'h1, (st == 0) ? 4'h6 : 4'h0);
         end
      end
      mode_strap <= 2'h2;
      dm.xfer('{8'hA8, 8'h20, 8'h02, 8'h00, 8'h00}, 3, 9);
      pc(2'h2, 3'h2, 4'h0);
      dm.xfer('{8'hA8, 8'h31, 8'h02, 8'h00, 8'h00}, 3, 9);
      {flat_gain_select, linearity_level_select} <= 4'(rnd());
      pc(2'h2, 3'h4, 4'h2);
      dm.xfer('{8'hA8, 8'h31, 8'hA9, 8'h04, 8'h00}, 4, 2);
      pc(2'h2, 3'h4, 4'h4);
      dm.xfer('{8'hAA, 8'h31, 8'h01, 8'h00, 8'h00}, 3, 9);
      pc(2'h2, 3'h4, 4'h4);
      dm.xfer('{8'hA8, 8'h40, 8'h11, 8'h22, 8'h33}, 5, 9);
      rd(`DSMC_ADDR_SNP1, 34'h332211, 34'hFFFFFF);
      dm.xfer('{8'hA8, 8'h35, 8'h5A, 8'h00, 8'h00}, 3, 9);
      rd(`DSMC_ADDR_SNP0, 34'h5A0402, 34'hFFFFFF);
      hpd <= 1'b0;
      hold(30);
      rd(`DSMC_ADDR_SNP0, 34'h0, 34'hFFFFFF);
      rd(`DSMC_ADDR_STAT, 34'h5, 34'h7);
      hpd <= 1'b1;
      hold(30);
      pc(2'h2, 3'h1, 4'h0);
      print_verdict;
   end
endmodule
`default_nettype wire
